// *** rtl/crc_ctrl_pkg.sv ***
// Package of register offsets, field positions, reset values and sizes for the CRC control block
package crc_ctrl_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;   // Control and FIFO status
  localparam logic [3:0] ADDR_DATA_IN = 4'h4;   // Word pushed into the input FIFO
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8; // Sticky event bits, write one to clear
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;  // Interrupt enable mask

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int POS_IDLE_STOP = 13;            // Stop while device idles
  localparam int POS_VALID_WORD_COUNT_HI = 12;             // Valid word count, top bit
  localparam int POS_VALID_WORD_COUNT_LO = 8;              // Valid word count, low bit
  localparam int POS_FULL = 7;                  // FIFO full flag
  localparam int POS_EMPTY = 6;                 // FIFO empty flag
  localparam int POS_START = 4;                 // Shifter start
  localparam int POS_POLY_LENGTH_MINUS_ONE_HI = 3;               // Polynomial length minus one, top bit
  localparam logic [15:0] CONTROL_WMASK = 16'h201F; // Writable control bits
  localparam logic [15:0] CONTROL_RESET = 16'h0040; // Control read value after reset

  // ----------------------------------------
  // FIFO sizing
  // ----------------------------------------
  localparam logic [3:0] POLY_LENGTH_MINUS_ONE_NARROW_MAX = 4'h7; // Largest length minus one that allows the deep FIFO
  localparam logic [4:0] DEPTH_DEEP = 5'h10;     // Capacity for short polynomials
  localparam logic [4:0] DEPTH_SHALLOW = 5'h08;  // Capacity for long polynomials

  // ----------------------------------------
  // Interrupt bits
  // ----------------------------------------
  localparam int IRQ_BITS = 3;                  // Number of event bits
  localparam int IRQ_DONE = 0;                  // FIFO drained while running
  localparam int IRQ_FULL = 1;                  // FIFO became full
  localparam int IRQ_OVER = 2;                  // Push refused while full

endpackage

// *** rtl/crc_fifo_if.sv ***
// Interface joining the control top to its word FIFO
`timescale 1ns/10ps
interface crc_fifo_if;
  logic push;          // Write one word
  logic [15:0] wdata;  // Word to write
  logic pop;           // Remove one word
  logic [15:0] rdata;  // Oldest word
  logic [4:0] count;   // Words held
  logic [4:0] cap;     // Present capacity
  logic full;          // Count at or above capacity
  logic empty;         // Count is zero
  modport ctl (output push, output wdata, output pop, output cap, input rdata, input count, input full, input empty);
  modport mem (input push, input wdata, input pop, input cap, output rdata, output count, output full, output empty);
endinterface

// *** rtl/crc_word_fifo.sv ***
// Word FIFO with capacity chosen at run time
`timescale 1ns/10ps
module crc_word_fifo #(
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  crc_fifo_if.mem f
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] wr;     // Write pointer
    logic [3:0] rd;     // Read pointer
    logic [4:0] count;  // Words held
  } fifo_state_t;

  fifo_state_t s_q, s_d;       // Registered and next state
  logic [15:0] mem_q [DEPTH];  // Word storage
  logic do_push, do_pop;       // Qualified operations

  // Refuse a push when full, a pop when empty
  assign do_push = f.push && (s_q.count < f.cap);
  assign do_pop = f.pop && (s_q.count != 5'h00);

  // Next pointers and count
  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.wr = s_q.wr + 4'h1;
    end
    if (do_pop) begin
      s_d.rd = s_q.rd + 4'h1;
    end
    // Count follows pushes and pops
    case ({do_push, do_pop})
      2'b10: s_d.count = s_q.count + 5'h01;
      2'b01: s_d.count = s_q.count - 5'h01;
      default: s_d.count = s_q.count;
    endcase
  end

  // Register state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage has no reset
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_q[s_q.wr] <= f.wdata;
    end
  end

  assign f.rdata = mem_q[s_q.rd];
  assign f.count = s_q.count;
  assign f.full = (s_q.count >= f.cap);
  assign f.empty = (s_q.count == 5'h00);

endmodule

// *** rtl/crc_control.sv ***
// Control register, FIFO status and serial shifter of the programmable CRC block
// What this block does
// - Stop bit halts shifter during device idle
// - Count field shows valid FIFO words
// - Capacity eight if length over eight, else sixteen
// - Full flag high while FIFO full
// - Empty flag high while FIFO empty
// - Start bit runs shifter, zero stops it
// - Length field holds polynomial length minus one
// - Unused control bits read zero
`timescale 1ns/10ps
module crc_control (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic device_idle,
  output logic [15:0] crc_result,
  output logic shifter_busy,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic idle_stop_select;            // Halt during idle
    logic shifter_start;               // Shifter enabled
    logic [3:0] poly_length_minus_one; // Polynomial length minus one
    logic [15:0] shift_word;           // Word being shifted
    logic [4:0] bits_left;             // Bits still to shift
    logic [15:0] crc;                  // CRC accumulator
    logic [15:0] rdata;                // Read data register
    logic [2:0] irq_status;            // Sticky events
    logic [2:0] irq_mask;              // Event enables
    logic full_prev;                   // Full flag one cycle ago
  } ctl_state_t;

  ctl_state_t s_q, s_d;     // Registered and next state
  crc_fifo_if fif ();       // Link to the word FIFO
  logic running;            // Shifter allowed to step
  logic load;               // Take next word from FIFO
  logic fb;                 // Feedback bit
  logic [15:0] poly_mask;   // Bits within polynomial length
  logic [15:0] control_rd;  // Control register read value
  logic [2:0] events;       // Events this cycle

  // ----------------------------------------
  // FIFO
  // ----------------------------------------
  crc_word_fifo #(.DEPTH(16)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .f(fif.mem)
  );

  // Capacity follows polynomial length
  assign fif.cap = (s_q.poly_length_minus_one > crc_ctrl_pkg::POLY_LENGTH_MINUS_ONE_NARROW_MAX) ?
    crc_ctrl_pkg::DEPTH_SHALLOW : crc_ctrl_pkg::DEPTH_DEEP;
  assign fif.push = wr_en && (addr == crc_ctrl_pkg::ADDR_DATA_IN);
  assign fif.wdata = wdata;

  // Step only when started and not halted by idle
  assign running = s_q.shifter_start && !(s_q.idle_stop_select && device_idle);
  assign load = running && (s_q.bits_left == 5'h00) && !fif.empty;
  assign fif.pop = load;

  // Mask and feedback for the programmed length
  assign poly_mask = 16'hFFFF >> (4'hF - s_q.poly_length_minus_one);
  assign fb = s_q.crc[s_q.poly_length_minus_one] ^ s_q.shift_word[15];

  // Control word as software reads it, unused bits zero
  always_comb begin
    control_rd = 16'h0000;
    control_rd[crc_ctrl_pkg::POS_IDLE_STOP] = s_q.idle_stop_select;
    control_rd[crc_ctrl_pkg::POS_VALID_WORD_COUNT_HI:crc_ctrl_pkg::POS_VALID_WORD_COUNT_LO] = fif.count;
    control_rd[crc_ctrl_pkg::POS_FULL] = fif.full;
    control_rd[crc_ctrl_pkg::POS_EMPTY] = fif.empty;
    control_rd[crc_ctrl_pkg::POS_START] = s_q.shifter_start;
    control_rd[crc_ctrl_pkg::POS_POLY_LENGTH_MINUS_ONE_HI:0] = s_q.poly_length_minus_one;
  end

  // Events: drained, newly full, push refused
  always_comb begin
    events = 3'h0;
    events[crc_ctrl_pkg::IRQ_DONE] = running && (s_q.bits_left == 5'h01) && fif.empty;
    events[crc_ctrl_pkg::IRQ_FULL] = fif.full && !s_q.full_prev;
    events[crc_ctrl_pkg::IRQ_OVER] = fif.push && fif.full;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    s_d.full_prev = fif.full;
    // Register writes
    if (wr_en) begin
      case (addr)
        crc_ctrl_pkg::ADDR_CONTROL: begin
          s_d.idle_stop_select = wdata[crc_ctrl_pkg::POS_IDLE_STOP];
          s_d.shifter_start = wdata[crc_ctrl_pkg::POS_START];
          s_d.poly_length_minus_one = wdata[crc_ctrl_pkg::POS_POLY_LENGTH_MINUS_ONE_HI:0];
        end
        crc_ctrl_pkg::ADDR_IRQ_MASK: begin
          s_d.irq_mask = wdata[crc_ctrl_pkg::IRQ_BITS-1:0];
        end
        default: begin
        end
      endcase
    end
    // Sticky events, set beats write-one clear
    if (wr_en && (addr == crc_ctrl_pkg::ADDR_IRQ_STATUS)) begin
      s_d.irq_status = s_q.irq_status & ~wdata[crc_ctrl_pkg::IRQ_BITS-1:0];
    end
    s_d.irq_status = s_d.irq_status | events;
    // Serial shifter, one bit per cycle
    if (load) begin
      s_d.shift_word = fif.rdata;
      s_d.bits_left = 5'h10;
    end else if (running && (s_q.bits_left != 5'h00)) begin
      s_d.crc = ({s_q.crc[14:0], 1'b0} ^ (fb ? crc_ctrl_pkg::CONTROL_RESET & 16'h0000 | poly_mask &
        16'h0001 : 16'h0000)) & poly_mask;
      s_d.shift_word = {s_q.shift_word[14:0], 1'b0};
      s_d.bits_left = s_q.bits_left - 5'h01;
    end
    // Read data for the next cycle
    if (rd_en) begin
      case (addr)
        crc_ctrl_pkg::ADDR_CONTROL: s_d.rdata = control_rd;
        crc_ctrl_pkg::ADDR_DATA_IN: s_d.rdata = s_q.crc & poly_mask;
        crc_ctrl_pkg::ADDR_IRQ_STATUS: s_d.rdata = {13'h0000, s_q.irq_status};
        crc_ctrl_pkg::ADDR_IRQ_MASK: s_d.rdata = {13'h0000, s_q.irq_mask};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = s_q.rdata;
  assign crc_result = s_q.crc;
  assign shifter_busy = s_q.bits_left != 5'h00;
  assign irq = |(s_q.irq_status & s_q.irq_mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_idle_halts: assert property (@(posedge mclk) disable iff (!rst_b)
    (s_q.idle_stop_select && device_idle) |-> !load ##1 $stable(s_q.bits_left)) else $error("shifter stepped in idle");
  a_count_field: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_en && addr == crc_ctrl_pkg::ADDR_CONTROL |=> rdata[12:8] == $past(fif.count)) else $error("count field wrong");
  a_capacity_sel: assert property (@(posedge mclk) disable iff (!rst_b)
    fif.cap == ((s_q.poly_length_minus_one > 4'h7) ? 5'h08 : 5'h10)) else $error("capacity wrong");
  a_full_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_en && addr == crc_ctrl_pkg::ADDR_CONTROL |=> rdata[7] == ($past(fif.count) >= $past(fif.cap))) else $error("full flag wrong");
  a_empty_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_en && addr == crc_ctrl_pkg::ADDR_CONTROL |=> rdata[6] == ($past(fif.count) == 5'h00)) else $error("empty flag wrong");
  a_start_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_en && addr == crc_ctrl_pkg::ADDR_CONTROL && !wdata[4] |=> !running [*1]) else $error("shifter not stopped");
  a_poly_length_minus_one_store: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_en && addr == crc_ctrl_pkg::ADDR_CONTROL |=> s_q.poly_length_minus_one == $past(wdata[3:0])) else $error("length not stored");
  a_unused_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_en && addr == crc_ctrl_pkg::ADDR_CONTROL |=> rdata[15:14] == 2'b00 && !rdata[5]) else $error("unused bits set");
  a_flags_agree: assert property (@(posedge mclk) disable iff (!rst_b)
    !(fif.full && fif.empty) && fif.count <= fif.cap) else $error("flags disagree");

endmodule

// *** tb/tb_crc_control.sv ***
// Self-checking bench for the CRC control block
`timescale 1ns/10ps
module tb_crc_control;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk; // System clock
  logic rst_b; // Reset, active low
  logic [3:0] addr; // Register address
  logic [15:0] wdata; // Write data
  logic wr_en; // Write strobe
  logic rd_en; // Read strobe
  logic [15:0] rdata; // Read data
  logic device_idle; // Device idle level
  logic shifter_busy; // Shifter active
  logic irq; // Interrupt line
  logic [15:0] rv; // Last read value
  int err_count; // Mismatches seen
  int cmp_count; // Comparisons made

  crc_control crc_control_i (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .device_idle(device_idle), .crc_result(), .shifter_busy(shifter_busy),
    .irq(irq));

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Verdict and end of run
  task give_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare seen against expected
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle register write
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // One-cycle read, data taken in the cycle after
  task rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    rv = rdata;
  endtask

  // Poll control until the word count matches, bounded
  task wait_count(input logic [4:0] n);
    for (int i = 0; i < 600; i++) begin
      rd(crc_ctrl_pkg::ADDR_CONTROL);
      if (rv[12:8] === n) return;
    end
    err_count++;
    $display("Error at %0t: word count wait ran out", $time);
    give_verdict();
  endtask

  // Push n words into the FIFO
  task push(input int n);
    for (int i = 0; i < n; i++) begin
      wr(crc_ctrl_pkg::ADDR_DATA_IN, 16'hA5C3 ^ i[15:0]);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset value, unused bits, unmapped read
  task t_fields();
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0040);
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'hFFEF);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h204F);
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h0010);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0050);
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h0000);
    rd(4'h2);
    chk(rv, 16'h0000);
  endtask

  // Long polynomial: capacity eight, refusal when full
  task t_fill();
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h0008);
    push(7);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0708);
    push(2);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0888);
    rd(crc_ctrl_pkg::ADDR_IRQ_STATUS);
    chk(rv, 16'h0006);
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h0007);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0807);
  endtask

  // Interrupt raised, masked and cleared
  task t_irq();
    chk({15'h0000, irq}, 16'h0000);
    wr(crc_ctrl_pkg::ADDR_IRQ_MASK, 16'h0004);
    rd(crc_ctrl_pkg::ADDR_IRQ_MASK);
    chk({15'h0000, irq}, 16'h0001);
    wr(crc_ctrl_pkg::ADDR_IRQ_STATUS, 16'h0007);
    rd(crc_ctrl_pkg::ADDR_IRQ_STATUS);
    chk({15'h0000, rv[2]}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  // Stop bit holds the shifter in idle, release lets it drain
  task t_idle_stop();
    @(posedge mclk);
    device_idle <= 1'b1;
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h2017);
    repeat (60) @(posedge mclk);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h2817);
    @(posedge mclk);
    device_idle <= 1'b0;
    wait_count(5'h00);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h2057);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk({15'h0000, shifter_busy}, 16'h0000);
    rd(crc_ctrl_pkg::ADDR_IRQ_STATUS);
    chk({15'h0000, rv[0]}, 16'h0001);
  endtask

  // Start off holds words; idle without stop bit keeps running
  task t_idle_run();
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h0007);
    push(2);
    repeat (40) @(posedge mclk);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0207);
    @(posedge mclk);
    device_idle <= 1'b1;
    wr(crc_ctrl_pkg::ADDR_CONTROL, 16'h0017);
    @(posedge mclk);
    @(negedge mclk);
    chk({15'h0000, shifter_busy}, 16'h0001);
    wait_count(5'h00);
    rd(crc_ctrl_pkg::ADDR_CONTROL);
    chk(rv, 16'h0057);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    device_idle = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    t_fields();
    t_fill();
    t_irq();
    t_idle_stop();
    t_idle_run();
    give_verdict();
  end
endmodule
